// ==== core/ierpc_pkg.sv ====
package ierpc_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int MCLK_HZ       = 125_000_000;
  localparam int TWC_MS        = 5;
  localparam int TWC_CYCLES    = TWC_MS * (MCLK_HZ / 1000);
  localparam int TWC_CNT_W     = 20;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int PTR_W         = 14;
  localparam int PAGE_BITS     = 5;
  localparam int ZONE_W        = 2;

  // ---------------------------------------------------------------
  // Address byte fields
  // ---------------------------------------------------------------
  localparam int TYPE_MSB      = 7;
  localparam int TYPE_LSB      = 4;
  localparam int CADDR_MSB     = 3;
  localparam int CADDR_LSB     = 1;
  localparam int RW_BIT        = 0;
  localparam int CFG_SEL_BIT   = 7;

  // ---------------------------------------------------------------
  // Configuration register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [1:0] WRITE_PROTECT_CONTROL  = 2'h0;
  localparam logic [1:0] CLIENT_ADDRESS_SETTING = 2'h1;
  localparam int CFG_WRITE_ENABLE_BIT      = 6;
  localparam int LOCK_CHECK_BIT            = 5;
  localparam int PROTECTION_ENABLE_BIT     = 3;
  localparam int PROTECT_ZONE_MSB          = 2;
  localparam int PROTECT_ZONE_LSB          = 1;
  localparam int CFG_LOCK_BIT              = 0;
  localparam int ADDR_REG_WRITE_ENABLE_BIT = 6;
  localparam int CLIENT_LSB_CHECK_BIT      = 5;
  localparam int CLIENT_ADDR_MSB           = 2;
  localparam int CLIENT_ADDR_BIT0          = 0;

  // Arbitrary neutral values
  localparam logic [3:0] DEV_TYPE_DEFAULT     = 4'h5;
  localparam logic [2:0] CLIENT_PRESET_DEFAULT = 3'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_HACK = 5'h10
  } ierpc_phase_t;

  typedef struct packed {
    logic tgl;
    logic bitv;
  } ierpc_link_t;

  typedef struct packed {
    logic                 sclMeta;
    logic                 sclSyn;
    logic                 sclPrev;
    logic                 sdaMeta;
    logic                 sdaSyn;
    logic                 sdaPrev;
    logic                 tglMeta;
    logic                 tglSyn;
    logic                 tglPrev;
    ierpc_phase_t         phase;
    logic [3:0]           bitCnt;
    logic [1:0]           byteNo;
    logic [7:0]           shReg;
    logic [7:0]           txSh;
    logic                 rw;
    logic                 cfgAcc;
    logic                 ackNow;
    logic                 more;
    logic [7:0]           wordHi;
    logic [PTR_W-1:0]     ptr;
    logic [1:0]           cfgIdx;
    logic                 wpEn;
    logic [ZONE_W-1:0]    zone;
    logic                 lock;
    logic [2:0]           clientAddr;
    logic [7:0]           stWpr;
    logic [7:0]           stHar;
    logic [1:0]           cfgCnt;
    logic                 memPend;
    logic                 busy;
    logic [TWC_CNT_W-1:0] twcCnt;
    logic                 sdaOe;
    logic                 sdaOut;
  } ierpc_state_t;

endpackage

// ==== core/ierpc_device.sv ====
// Behaviour
// RULE_01 - Address byte gets NACK while write cycle runs, ACK once finished.
// RULE_02 - Host polls after Stop with Start plus write address until ACK.
// RULE_03 - After address change host polls new address; no ACK by twc means failed.
// RULE_04 - Array split into four zones: upper quarter, half, three quarters, whole.
// RULE_05 - Largest density zones start at 3000h, 2000h, 1000h, 0000h up to 3FFFh.
// RULE_06 - Protection setting becomes fixed once configuration registers are locked.
// RULE_07 - Address byte with direction bit 1 starts a read.
// RULE_08 - Pointer holds last accessed address plus one; current read uses it.
// RULE_09 - Current read: ACK matching read address, then shift out byte at pointer.
// RULE_10 - Host NACK on ninth clock ends the read; device goes to standby.
// RULE_11 - After read NACK host ends with Stop or starts anew.
// RULE_12 - Random read: write address, word address MSb 0, repeated Start, read.
// RULE_13 - Repeated Start after word address abandons write but keeps pointer load.
// RULE_14 - After random read the pointer sits at read address plus one.
// RULE_15 - Each host ACK in sequential read advances address and sends next byte.
// RULE_16 - Pointer wraps from highest address to 0000h on host ACK.
// RULE_17 - Two 8-bit configuration registers, byte 0 protection, byte 1 address.
// RULE_18 - Field layout of protection control and client address bytes.
// RULE_19 - Once locked, both configuration registers refuse any change.
// RULE_20 - Registers read by random read, written by single byte-write sequence.
// RULE_21 - Address byte: 4-bit type code, three client bits, direction bit 0.
// RULE_22 - ACK only when client bits equal current address register value.
// RULE_23 - Register access ignores word address bits except MSb, which must be 1.
// RULE_24 - Write ignored unless enable is 1 and check matches; both read as 0.
// RULE_25 - Protection off: none; on: zone 00,01,10,11 quarter, half, 3/4, whole.
module ierpc_device #(
  parameter int         ADDR_W        = ierpc_pkg::PTR_W,
  parameter int         TWC_CYCLES    = ierpc_pkg::TWC_CYCLES,
  parameter logic [3:0] DEV_TYPE      = ierpc_pkg::DEV_TYPE_DEFAULT,
  parameter logic [2:0] CLIENT_PRESET = ierpc_pkg::CLIENT_PRESET_DEFAULT
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic serialClk,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  output logic      writeBusy,
  output logic      cfgLocked
);

  // ---------------------------------------------------------------
  // Link side: sample data on each serial clock rise
  // ---------------------------------------------------------------
  ierpc_pkg::ierpc_link_t lk;
  ierpc_pkg::ierpc_link_t next_lk;

  always_comb begin
    next_lk      = lk;
    next_lk.bitv = sdaIn;
    next_lk.tgl  = ~lk.tgl;
  end

  always_ff @(posedge serialClk or negedge resetn) begin
    if (!resetn) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ---------------------------------------------------------------
  // Storage array
  // ---------------------------------------------------------------
  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0]                      mem [DEPTH];
  logic                            memWe;
  logic [ADDR_W-1:0]               memWa;
  logic [7:0]                      memWd;

  always_ff @(posedge mclk) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  // ---------------------------------------------------------------
  // Main state
  // ---------------------------------------------------------------
  ierpc_pkg::ierpc_state_t s;
  ierpc_pkg::ierpc_state_t n;

  localparam logic [ierpc_pkg::PTR_W-1:0] ADDR_MASK =
    ierpc_pkg::PTR_W'((ierpc_pkg::PTR_W + 1)'(DEPTH) - 1'b1);
  localparam logic [ierpc_pkg::TWC_CNT_W-1:0] TWC_LAST =
    ierpc_pkg::TWC_CNT_W'(TWC_CYCLES - 1);

  logic                        sclFall;
  logic                        startEv;
  logic                        stopEv;
  logic                        bitEv;
  logic [7:0]                  nb;
  logic [7:0]                  cfgByte;
  logic [7:0]                  rdData;
  logic [1:0]                  zoneMsbs;
  logic                        protHit;
  logic [ierpc_pkg::PTR_W-1:0] ptrNext;

  assign sclFall  = s.sclPrev & ~s.sclSyn;
  assign startEv  = s.sclSyn & s.sclPrev & s.sdaPrev & ~s.sdaSyn;
  assign stopEv   = s.sclSyn & s.sclPrev & ~s.sdaPrev & s.sdaSyn;
  assign bitEv    = s.tglSyn ^ s.tglPrev;
  assign nb       = {s.shReg[6:0], lk.bitv};
  assign ptrNext  = (s.ptr + 1'b1) & ADDR_MASK;                            // see RULE_16
  assign zoneMsbs = s.ptr[ADDR_W-1 -: 2];
  assign protHit  = s.wpEn & (zoneMsbs >= (2'h3 - s.zone));                 // see RULE_25
  assign rdData   = s.cfgAcc ? cfgByte : mem[s.ptr[ADDR_W-1:0]];

  // Enable and check bits always read back as zero
  always_comb begin
    cfgByte = 8'h00;
    if (s.cfgIdx == ierpc_pkg::WRITE_PROTECT_CONTROL) begin                // see RULE_24
      cfgByte[ierpc_pkg::PROTECTION_ENABLE_BIT] = s.wpEn;
      cfgByte[ierpc_pkg::PROTECT_ZONE_MSB:ierpc_pkg::PROTECT_ZONE_LSB] = s.zone;
      cfgByte[ierpc_pkg::CFG_LOCK_BIT] = s.lock;
    end else begin
      cfgByte[ierpc_pkg::CLIENT_ADDR_MSB:ierpc_pkg::CLIENT_ADDR_BIT0] = s.clientAddr;
    end
  end

  always_comb begin
    n         = s;
    memWe     = 1'b0;
    memWa     = s.ptr[ADDR_W-1:0];
    memWd     = nb;
    n.sclMeta = sclIn;
    n.sclSyn  = s.sclMeta;
    n.sclPrev = s.sclSyn;
    n.sdaMeta = sdaIn;
    n.sdaSyn  = s.sdaMeta;
    n.sdaPrev = s.sdaSyn;
    n.tglMeta = lk.tgl;
    n.tglSyn  = s.tglMeta;
    n.tglPrev = s.tglSyn;
    n.sdaOut  = 1'b0;

    // ---------------------------------------------------------------
    // Self-timed write cycle
    // ---------------------------------------------------------------
    if (s.busy) begin
      if (s.twcCnt == TWC_LAST) begin
        n.busy = 1'b0;
      end else begin
        n.twcCnt = s.twcCnt + 1'b1;
      end
    end

    // ---------------------------------------------------------------
    // Bus conditions and byte engine
    // ---------------------------------------------------------------
    if (stopEv) begin
      n.phase = ierpc_pkg::ST_IDLE;
      n.sdaOe = 1'b0;
      if ((s.memPend || s.cfgCnt != 2'h0) && !s.busy) begin
        n.busy   = 1'b1;
        n.twcCnt = '0;
        if (s.cfgCnt != 2'h0) begin                                        // see RULE_20
          n.wpEn = s.stWpr[ierpc_pkg::PROTECTION_ENABLE_BIT];
          n.zone = s.stWpr[ierpc_pkg::PROTECT_ZONE_MSB:ierpc_pkg::PROTECT_ZONE_LSB];
          n.lock = s.stWpr[ierpc_pkg::CFG_LOCK_BIT];                       // see RULE_06
        end
        if (s.cfgCnt == 2'h2) begin
          n.clientAddr = s.stHar[ierpc_pkg::CLIENT_ADDR_MSB:ierpc_pkg::CLIENT_ADDR_BIT0];
        end
      end
      n.memPend = 1'b0;
      n.cfgCnt  = 2'h0;
    end else if (startEv) begin
      // A repeated start drops any pending write; the pointer stays loaded
      n.phase   = ierpc_pkg::ST_RX;                                         // see RULE_13
      n.bitCnt  = 4'h0;
      n.byteNo  = 2'h0;
      n.sdaOe   = 1'b0;
      n.memPend = 1'b0;
      n.cfgCnt  = 2'h0;
    end else begin
      case (s.phase)
        ierpc_pkg::ST_RX: begin
          if (bitEv && s.bitCnt != 4'h8) begin
            n.shReg  = nb;
            n.bitCnt = s.bitCnt + 1'b1;
            if (s.bitCnt == 4'h7) begin
              n.ackNow = 1'b1;
              case (s.byteNo)
                2'h0: begin
                  n.rw     = nb[ierpc_pkg::RW_BIT];                         // see RULE_07
                  n.ackNow = (nb[ierpc_pkg::TYPE_MSB:ierpc_pkg::TYPE_LSB] == DEV_TYPE) &&
                             (nb[ierpc_pkg::CADDR_MSB:ierpc_pkg::CADDR_LSB] == s.clientAddr) &&
                             !s.busy;                                       // see RULE_01 RULE_21 RULE_22
                end
                2'h1: begin
                  n.wordHi = nb;
                  n.cfgAcc = nb[ierpc_pkg::CFG_SEL_BIT];                    // see RULE_23
                end
                2'h2: begin
                  if (s.cfgAcc) begin
                    n.cfgIdx = ierpc_pkg::WRITE_PROTECT_CONTROL;            // see RULE_17
                  end else begin
                    n.ptr = ierpc_pkg::PTR_W'({s.wordHi, nb}) & ADDR_MASK;    // see RULE_12
                  end
                end
                default: begin
                  if (s.cfgAcc) begin
                    if (s.cfgCnt == 2'h0 && !s.lock &&
                        nb[ierpc_pkg::CFG_WRITE_ENABLE_BIT] &&
                        nb[ierpc_pkg::LOCK_CHECK_BIT] == s.lock) begin      // see RULE_18 RULE_19 RULE_24
                      n.stWpr  = nb;
                      n.cfgCnt = 2'h1;
                    end else if (s.cfgCnt == 2'h1 &&
                                 nb[ierpc_pkg::ADDR_REG_WRITE_ENABLE_BIT] &&
                                 nb[ierpc_pkg::CLIENT_LSB_CHECK_BIT] ==
                                 nb[ierpc_pkg::CLIENT_ADDR_BIT0]) begin     // see RULE_18
                      n.stHar  = nb;
                      n.cfgCnt = 2'h2;
                    end else begin
                      // Invalid or surplus byte aborts the whole update
                      n.ackNow = 1'b0;
                      n.cfgCnt = 2'h0;
                    end
                  end else begin
                    if (!protHit) begin                                     // see RULE_04 RULE_05
                      memWe     = 1'b1;
                      n.memPend = 1'b1;
                    end
                    n.ptr[ierpc_pkg::PAGE_BITS-1:0] = s.ptr[ierpc_pkg::PAGE_BITS-1:0] + 1'b1;
                  end
                end
              endcase
            end
          end else if (sclFall && s.bitCnt == 4'h8) begin
            if (s.ackNow) begin
              n.sdaOe = 1'b1;
              n.phase = ierpc_pkg::ST_ACK;
            end else begin
              n.phase = ierpc_pkg::ST_IDLE;
            end
          end
        end
        ierpc_pkg::ST_ACK: begin
          if (sclFall) begin
            n.bitCnt = 4'h0;
            if (s.byteNo == 2'h0 && s.rw) begin                             // see RULE_09 RULE_08
              n.txSh  = rdData;
              n.sdaOe = ~rdData[7];
              n.phase = ierpc_pkg::ST_TX;
            end else begin
              n.sdaOe = 1'b0;
              n.phase = ierpc_pkg::ST_RX;
              if (s.byteNo != 2'h3) begin
                n.byteNo = s.byteNo + 1'b1;
              end
            end
          end
        end
        ierpc_pkg::ST_TX: begin
          if (sclFall) begin
            if (s.bitCnt == 4'h7) begin
              n.sdaOe = 1'b0;
              n.more  = 1'b0;
              n.phase = ierpc_pkg::ST_HACK;
              if (s.cfgAcc) begin
                n.cfgIdx = s.cfgIdx ^ ierpc_pkg::CLIENT_ADDRESS_SETTING;
              end else begin
                n.ptr = ptrNext;                                            // see RULE_14 RULE_16
              end
            end else begin
              n.bitCnt = s.bitCnt + 1'b1;
              n.txSh   = {s.txSh[6:0], 1'b0};
              n.sdaOe  = ~s.txSh[6];
            end
          end
        end
        ierpc_pkg::ST_HACK: begin
          if (bitEv) begin
            n.more = ~lk.bitv;
            if (lk.bitv) begin
              n.phase = ierpc_pkg::ST_IDLE;                                 // see RULE_10
            end
          end else if (sclFall && s.more) begin
            n.bitCnt = 4'h0;
            n.txSh   = rdData;                                              // see RULE_15
            n.sdaOe  = ~rdData[7];
            n.phase  = ierpc_pkg::ST_TX;
          end
        end
        ierpc_pkg::ST_IDLE: begin
          n.sdaOe = 1'b0;
        end
        default: begin
          n.phase = ierpc_pkg::ST_IDLE;
          n.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s            <= '0;
      s.sclMeta    <= 1'b1;
      s.sclSyn     <= 1'b1;
      s.sclPrev    <= 1'b1;
      s.sdaMeta    <= 1'b1;
      s.sdaSyn     <= 1'b1;
      s.sdaPrev    <= 1'b1;
      s.phase      <= ierpc_pkg::ST_IDLE;
      s.clientAddr <= CLIENT_PRESET;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sdaOut    = s.sdaOut;
  assign sdaOe     = s.sdaOe;
  assign writeBusy = s.busy;
  assign cfgLocked = s.lock;

endmodule

// ==== dv/ierpc_properties.sv ====
module ierpc_properties #(
  parameter int TWC_CYCLES = ierpc_pkg::TWC_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic serialClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic writeBusy,
  input wire logic cfgLocked
);
  logic [31:0] busyCnt;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busyCnt <= 32'h0;
    end else begin
      busyCnt <= writeBusy ? busyCnt + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence idleBus;
    sclIn && sdaIn;
  endsequence

  open_drain_a: assert property (sdaOut == 1'h0)
    else $error("data pin driven high");
  drive_low_a: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data line pulled while clock high");
  release_low_a: assert property ($fell(sdaOe) |-> !sclIn)
    else $error("data line released while clock high");
  busy_silent_a: assert property (writeBusy |-> !sdaOe)
    else $error("device answered during write cycle");
  busy_bound_a: assert property (busyCnt <= TWC_CYCLES + 2)
    else $error("write cycle overran its time");
  busy_at_stop_a: assert property ($rose(writeBusy) |-> idleBus)
    else $error("write cycle began outside a stop");
  lock_sticky_a: assert property (cfgLocked |=> cfgLocked)
    else $error("lock bit cleared");
  lock_at_stop_a: assert property ($rose(cfgLocked) |-> idleBus)
    else $error("lock set outside a stop");
endmodule

bind ierpc_device ierpc_properties #(.TWC_CYCLES(TWC_CYCLES)) u_props (
  .mclk(mclk), .resetn(resetn), .serialClk(serialClk), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy), .cfgLocked(cfgLocked));

// ==== dv/ierpc_host.sv ====
module ierpc_host (
  input  wire logic hclk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 6;

  // Bus idles high with the clock standing still
  initial begin
    sclOut = 1'h1;
    sdaLow = 1'h0;
  end

  task automatic waitHalf();
    repeat (HALF) @(posedge hclk);
  endtask

  task automatic bitIo(input logic b, output logic r);
    sdaLow = !b;
    waitHalf();
    sclOut = 1'h1;
    waitHalf();
    r = sdaLine;
    sclOut = 1'h0;
  endtask

  // Serves as first and repeated start alike
  task automatic start();
    sdaLow = 1'h0;
    waitHalf();
    sclOut = 1'h1;
    waitHalf();
    sdaLow = 1'h1;
    waitHalf();
    sclOut = 1'h0;
  endtask

  task automatic stop();
    sdaLow = 1'h1;
    waitHalf();
    sclOut = 1'h1;
    waitHalf();
    sdaLow = 1'h0;
    waitHalf();
  endtask

  // Eight bits out MSB first, then the ninth clock; last=1 releases the line
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(tx[i], r);
      rx[i] = r;
    end
    bitIo(last, r);
    ack = !r;
  endtask
endmodule

// ==== dv/i2c_eeprom_read_protect_cfg_tb.sv ====
module i2c_eeprom_read_protect_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] TYP = ierpc_pkg::DEV_TYPE_DEFAULT;
  logic       mclk, hclk, resetn, scl, hostLow, ok;
  wire logic  sdaOut, sdaOe, writeBusy, cfgLocked, sda;
  logic [2:0] cli, nextCli;
  logic [15:0] a0;
  logic [7:0] q [$];
  logic [7:0] w [$];
  int         failures, comparisons, nacks;

  assign sda = !(hostLow || sdaOe);
  ierpc_device #(.TWC_CYCLES(400)) u_dut (.mclk(mclk), .resetn(resetn), .serialClk(scl), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy), .cfgLocked(cfgLocked));
  ierpc_host u_host (.hclk(hclk), .sdaLine(sda), .sclOut(scl), .sdaLow(hostLow));

  initial begin
    mclk = 1'h0;
    forever #4 mclk = !mclk;
  end
  initial begin
    hclk = 1'h0;
    #3.3;
    forever #7.5 hclk = !hclk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] devAddr(input logic [2:0] c, input logic rw);
    return {TYP, c, rw};
  endfunction

  task automatic frame(input logic [7:0] b, output logic a);
    logic [7:0] rx;
    u_host.start();
    u_host.xfer(b, 1'h1, rx, a);
  endtask

  task automatic probe(input logic [7:0] b, input logic exp);
    logic a;
    frame(b, a);
    u_host.stop();
    check("addrAck", {7'h0, a}, {7'h0, exp});
  endtask

  task automatic poll();
    logic a;
    nacks = -1;
    a = 1'h0;
    while (!a && nacks < 12) begin
      frame(devAddr(nextCli, 1'h0), a);
      u_host.stop();
      nacks++;
    end
    check("pollAck", {7'h0, a}, 8'h01);
    cli = nextCli;
  endtask

  task automatic wr(input logic [15:0] wa, input logic [7:0] d [$], output logic allAck);
    logic [7:0] rx;
    logic a;
    allAck = 1'h1;
    frame(devAddr(cli, 1'h0), a);
    u_host.xfer(wa[15:8], 1'h1, rx, a);
    u_host.xfer(wa[7:0], 1'h1, rx, a);
    foreach (d[i]) begin
      u_host.xfer(d[i], 1'h1, rx, a);
      allAck &= a;
    end
    u_host.stop();
    poll();
  endtask

  task automatic rd(input logic [15:0] wa, input int n, output logic [7:0] r [$]);
    logic [7:0] b;
    logic a;
    r = {};
    frame(devAddr(cli, 1'h0), a);
    u_host.xfer(wa[15:8], 1'h1, b, a);
    u_host.xfer(wa[7:0], 1'h1, b, a);
    frame(devAddr(cli, 1'h1), a);
    check("readAck", {7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'hff, i == n - 1, b, a);
      r.push_back(b);
    end
    u_host.stop();
  endtask

  initial begin
    resetn = 1'h0;
    failures = 0;
    comparisons = 0;
    cli = ierpc_pkg::CLIENT_PRESET_DEFAULT;
    nextCli = cli;
    void'($urandom(39294));
    repeat (2) @(posedge mclk);
    resetn <= 1'h1;
    repeat (3) @(posedge mclk);
    rd(16'h8000, 2, q);
    check("protCtl", q[0], 8'h00);
    check("clientSet", q[1], {5'h0, cli});
    repeat (2) begin
      a0 = 16'($urandom) & 16'h3ffe;
      w = {8'($urandom), 8'($urandom)};
      wr(a0, w, ok);
      check("nackBusy", {7'h0, nacks > 0}, 8'h01);
      rd(a0, 1, q);
      check("randRead", q[0], w[0]);
      frame(devAddr(cli, 1'h1), ok);
      u_host.xfer(8'hff, 1'h1, q[0], ok);
      u_host.stop();
      check("curRead", q[0], w[1]);
    end
    wr(16'h3fff, {8'h5a}, ok);
    wr(16'h0000, {8'ha5}, ok);
    rd(16'h3fff, 2, q);
    check("wrap", q[1], 8'ha5);
    probe(devAddr(cli ^ 3'h1, 1'h0), 1'h0);
    probe({~TYP, cli, 1'h0}, 1'h0);
    for (int z = 0; z < 4; z++) begin
      a0 = 16'h3000 - 16'(z) * 16'h1000;
      wr(16'h8000, {8'h40}, ok);
      wr(a0, {8'h11}, ok);
      wr(16'h80ff, {8'h48 | 8'(z << 1)}, ok);
      wr(a0, {8'h22}, ok);
      wr((a0 - 16'h1) & 16'h3fff, {8'h22}, ok);
      rd((a0 - 16'h1) & 16'h3fff, 2, q);
      check("unprotected", q[0], z == 3 ? 8'h5a : 8'h22);
      check("protected", q[1], 8'h11);
    end
    foreach (w[i]) begin
      w = {8'h0e, 8'h6e};
      wr(16'h8000, {w[i]}, ok);
      check("badCfgAck", {7'h0, ok}, 8'h00);
    end
    wr(16'h8000, {8'h40, 8'h40, 8'h00}, ok);
    rd(16'hff00, 1, q);
    check("protCtl", q[0], 8'h0e);
    nextCli = 3'h5;
    wr(16'h8000, {8'h40, 8'h65}, ok);
    probe(devAddr(3'h0, 1'h0), 1'h0);
    rd(16'h8000, 2, q);
    check("clientSet", q[1], 8'h05);
    wr(16'h8000, {8'h41}, ok);
    check("locked", {7'h0, cfgLocked}, 8'h01);
    wr(16'h8000, {8'h6f}, ok);
    check("lockedAck", {7'h0, ok}, 8'h00);
    rd(16'h8000, 1, q);
    check("protCtl", q[0], 8'h01);
    close_out();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    close_out();
  end
endmodule
